// >>> hdl/idm_core.sv
// Internal 256-byte data memory with banks, bit space and stack pointer.
`timescale 1ns/1ps
`default_nettype none
`include "idm_regs.svh"

module idm_core
    import idm_pkg::*;
#(
    parameter int MEM_BYTES = `IDM_MEM_BYTES
)
(
    input  wire logic       clock_i,
    input  wire logic       nrst_i,
    input  wire logic       en_i,
    input  wire idm_op_t    op_i,
    input  wire logic [7:0] addr_i,
    input  wire logic       ptr_sel_i,
    input  wire logic       write_i,
    input  wire logic [7:0] wdata_i,
    input  wire logic       wbit_i,
    input  wire logic [7:0] program_status_word_i,
    input  wire logic       sp_load_i,
    input  wire logic [7:0] sp_wdata_i,
    output logic [7:0]      rdata_o,
    output logic            rbit_o,
    output logic            rvalid_o,
    output logic            special_req_o,
    output logic [7:0]      special_addr_o,
    output logic            special_write_o,
    output logic [7:0]      special_wdata_o,
    output logic [7:0]      stack_pointer_o
);

    // ****************************************************************
    // Parameter check
    // ****************************************************************

    // The decoder produces 8-bit addresses, so only a full 256 bytes fit.
    // The check runs at elaboration, so a bad size never reaches a run.
    if (MEM_BYTES != `IDM_MEM_BYTES) begin : g_bad_size
        $error("idm_core: MEM_BYTES must be 256");
    end

    // ****************************************************************
    // Usage notes
    // ****************************************************************

    // One access is taken on every enabled clock edge; there is no stall.
    // The core may issue a new request on every cycle, back to back.
    // Read results appear one edge after the request and hold until the
    // next enabled edge, so the core must capture them in that window.
    // A write is visible to a read taken on the following edge.
    // A read taken in the same cycle as a write to that byte sees the
    // old byte, because the array is written at the clock edge.
    // Indirect accesses read the pointer register from the array in the
    // same cycle, which keeps latency at one cycle but puts the array
    // read twice on the critical path; the array is small enough.
    // The bank bits are sampled combinationally from the status word, so
    // a bank change takes effect on the very next access.
    // Direct and bit accesses above the lower half are forwarded to the
    // special-function space on registered outputs; this block holds no
    // special-function registers itself.
    // The stack pointer load path beats a push or pop in the same cycle,
    // so the core's own pointer writes always win.
    // The stack pointer wraps modulo 256, so a runaway stack overwrites
    // the working-register banks rather than faulting; software must
    // size the stack.
    // The array has no reset: its contents survive a reset and start out
    // unknown after power-up until they are written.
    // The clock enable freezes every flip-flop, array included, so a
    // frozen cycle leaves no trace.

    // ****************************************************************
    // Storage and bank selection
    // ****************************************************************

    logic [7:0] mem [0:MEM_BYTES-1];
    logic [7:0] stack_pointer;

    wire logic       bank_select_low  = program_status_word_i[`IDM_BANK_LOW_POS];
    wire logic       bank_select_high = program_status_word_i[`IDM_BANK_HIGH_POS];
    wire logic [1:0] bank             = {bank_select_high, bank_select_low};

    wire logic [7:0] ptr_addr = `IDM_BANK_BASE + {3'h0, bank, 2'h0, ptr_sel_i};
    wire logic [7:0] ptr      = mem[ptr_addr];

    // ****************************************************************
    // Decode
    // ****************************************************************

    logic [7:0] ram_addr;
    idm_tgt_t   tgt;
    logic [2:0] bit_pos;

    idm_decode u_decode (
        .op_i       (op_i),
        .addr_i     (addr_i),
        .sp_i       (stack_pointer),
        .ptr_i      (ptr),
        .ram_addr_o (ram_addr),
        .tgt_o      (tgt),
        .bit_pos_o  (bit_pos)
    );

    wire logic       to_ram     = (tgt == IDM_TGT_RAM);
    wire logic       to_special = (tgt == IDM_TGT_SPECIAL);
    wire logic [7:0] cur_byte   = mem[ram_addr];
    wire logic       is_bit     = (op_i == IDM_OP_BIT);
    wire logic       is_push    = (op_i == IDM_OP_PUSH);
    wire logic       is_pop     = (op_i == IDM_OP_POP);

    logic [7:0] merged;
    always_comb begin
        merged          = cur_byte;
        merged[bit_pos] = wbit_i;
    end

    // Push always writes; pop never writes; other RAM-bound kinds write on request.
    wire logic       mem_we   = to_ram && (is_push || (write_i && !is_pop));
    wire logic [7:0] mem_wval = is_bit ? merged : wdata_i;

    wire logic [7:0] next_stack_pointer = sp_load_i ? sp_wdata_i :
                                          is_push   ? stack_pointer + 8'h01 :
                                          is_pop    ? stack_pointer - 8'h01 :
                                                      stack_pointer;

    // ****************************************************************
    // Memory array
    // ****************************************************************

    // no reset on the array, so contents survive a reset.
    always_ff @(posedge clock_i) begin
        if (en_i && mem_we) begin
            mem[ram_addr] <= mem_wval;
        end
    end

    // ****************************************************************
    // Stack pointer and registered outputs
    // ****************************************************************

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            stack_pointer <= `IDM_STACK_RESET;
        end else if (en_i) begin
            stack_pointer <= next_stack_pointer;
        end
    end

    // Read data is returned one cycle after the request, from flip-flops.
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rdata_o         <= 8'h00;
            rbit_o          <= 1'b0;
            rvalid_o        <= 1'b0;
            special_req_o   <= 1'b0;
            special_addr_o  <= 8'h00;
            special_write_o <= 1'b0;
            special_wdata_o <= 8'h00;
        end else if (en_i) begin
            rdata_o         <= to_ram ? cur_byte : 8'h00;
            rbit_o          <= to_ram && cur_byte[bit_pos];
            rvalid_o        <= to_ram && !write_i && !is_push;
            special_req_o   <= to_special;
            special_addr_o  <= to_special ? ram_addr : 8'h00;
            special_write_o <= to_special && write_i;
            special_wdata_o <= to_special ? wdata_i : 8'h00;
        end
    end

    // The pointer output mirrors the register so it follows reset at once.
    assign stack_pointer_o = stack_pointer;

endmodule // idm_core
`default_nettype wire

// >>> hdl/idm_decode.sv
// Address decoder that routes one access to RAM or special-function space.
`timescale 1ns/1ps
`default_nettype none
`include "idm_regs.svh"

module idm_decode
    import idm_pkg::*;
(
    input  wire idm_op_t    op_i,
    input  wire logic [7:0] addr_i,
    input  wire logic [7:0] sp_i,
    input  wire logic [7:0] ptr_i,
    output logic [7:0]      ram_addr_o,
    output idm_tgt_t        tgt_o,
    output logic [2:0]      bit_pos_o
);

    // ****************************************************************
    // Byte and bit address decode
    // ****************************************************************

    // Bit address: byte offset in bits 6 to 3, position in bits 2 to 0.
    wire logic [7:0] bit_byte = `IDM_BIT_BASE + {4'h0, addr_i[6:3]};
    wire logic       above    = (addr_i > `IDM_LOWER_TOP);

    // The target and address follow the access kind, and for direct and bit accesses also the address.
    always_comb begin
        ram_addr_o = 8'h00;
        tgt_o      = IDM_TGT_NONE;
        bit_pos_o  = addr_i[2:0];
        case (op_i)
            IDM_OP_DIRECT: begin
                ram_addr_o = addr_i;
                tgt_o      = above ? IDM_TGT_SPECIAL : IDM_TGT_RAM;
            end
            IDM_OP_INDIRECT: begin
                ram_addr_o = ptr_i;
                tgt_o      = IDM_TGT_RAM;
            end
            IDM_OP_BIT: begin
                ram_addr_o = above ? addr_i : bit_byte;
                tgt_o      = above ? IDM_TGT_SPECIAL : IDM_TGT_RAM;
            end
            IDM_OP_PUSH: begin
                ram_addr_o = sp_i + 8'h01;
                tgt_o      = IDM_TGT_RAM;
            end
            IDM_OP_POP: begin
                ram_addr_o = sp_i;
                tgt_o      = IDM_TGT_RAM;
            end
            default: begin
                ram_addr_o = 8'h00;
                tgt_o      = IDM_TGT_NONE;
            end
        endcase
    end

endmodule // idm_decode
`default_nettype wire

// >>> hdl/idm_pkg.sv
// Types shared by the internal data memory block.
package idm_pkg;

    // Kind of access requested by the core in one cycle.
    typedef enum logic [2:0] {
        IDM_OP_NONE,
        IDM_OP_DIRECT,
        IDM_OP_INDIRECT,
        IDM_OP_BIT,
        IDM_OP_PUSH,
        IDM_OP_POP
    } idm_op_t;

    // Where a decoded access lands.
    typedef enum logic [1:0] {
        IDM_TGT_NONE,
        IDM_TGT_RAM,
        IDM_TGT_SPECIAL
    } idm_tgt_t;

endpackage

// >>> hdl/idm_regs.svh
// Constants for the internal data memory block: addresses, fields and reset values.
`ifndef IDM_REGS_SVH
`define IDM_REGS_SVH

`define IDM_MEM_BYTES      256
`define IDM_LOWER_TOP      8'h7F
`define IDM_BANK_BASE      8'h00
`define IDM_BANK_TOP       8'h1F
`define IDM_BIT_BASE       8'h20
`define IDM_BIT_TOP        8'h2F
`define IDM_BANK_LOW_POS   3
`define IDM_BANK_HIGH_POS  4
`define IDM_STACK_RESET    8'h07

`endif

// >>> verification/idm_core_props.sv
// Concurrent checks on the ports of the internal data memory block.
`timescale 1ns/1ps
`default_nettype none
module idm_core_props
    import idm_pkg::*;
#(parameter int MEM_BYTES = 256)
(
    input wire logic       clock_i, nrst_i, en_i, ptr_sel_i, write_i, wbit_i, sp_load_i,
    input wire idm_op_t    op_i,
    input wire logic [7:0] addr_i, wdata_i, program_status_word_i, sp_wdata_i,
    input wire logic [7:0] rdata_o, special_addr_o, special_wdata_o, stack_pointer_o,
    input wire logic       rbit_o, rvalid_o, special_req_o, special_write_o
);
    // All checks sample on the core clock and stay quiet while reset is held.
    default clocking @(posedge clock_i); endclocking
    default disable iff (!nrst_i);
    wire logic run = en_i && !sp_load_i; // A pointer load overrides push and pop.
    a_push_sp_up: assert property (run && op_i == IDM_OP_PUSH |=> stack_pointer_o == $past(stack_pointer_o) + 8'h01)
        else $error("push did not raise the pointer");
    a_pop_sp_down: assert property (run && op_i == IDM_OP_POP |=> stack_pointer_o == $past(stack_pointer_o) - 8'h01)
        else $error("pop did not lower the pointer");
    a_sp_load_wins: assert property (en_i && sp_load_i |=> stack_pointer_o == $past(sp_wdata_i))
        else $error("pointer load lost");
    a_direct_hi_special: assert property (en_i && op_i == IDM_OP_DIRECT && addr_i[7] |=> special_req_o
        && special_addr_o == $past(addr_i) && special_write_o == $past(write_i)
        && special_wdata_o == $past(wdata_i)) else $error("direct high not forwarded");
    a_bit_hi_special: assert property (en_i && op_i == IDM_OP_BIT && addr_i[7] |=> special_req_o
        && special_addr_o == $past(addr_i)) else $error("high bit access not forwarded");
    a_indirect_ram_only: assert property (en_i && op_i == IDM_OP_INDIRECT |=> !special_req_o)
        else $error("indirect access forwarded");
    a_bit_low_ram: assert property (en_i && op_i == IDM_OP_BIT && !addr_i[7] |=> !special_req_o)
        else $error("low bit access forwarded");
    a_low_read_valid: assert property (en_i && op_i == IDM_OP_DIRECT && !addr_i[7] && !write_i |=> rvalid_o)
        else $error("low direct read gave no data");
    a_pop_read_valid: assert property (en_i && op_i == IDM_OP_POP |=> rvalid_o && !special_req_o)
        else $error("pop gave no data");
endmodule // idm_core_props
bind idm_core idm_core_props #(.MEM_BYTES(MEM_BYTES)) idm_core_props_inst (.*);
`default_nettype wire

// >>> verification/idm_core_tb.sv
// Self-checking bench for the internal data memory block.
`timescale 1ns/1ps
`default_nettype none
module idm_core_tb;
    import idm_pkg::*;
    logic clock_i = 0, nrst_i = 0, en_i = 1, ptr_sel_i = 0, write_i = 0, wbit_i = 0, sp_load_i = 0;
    logic [7:0] addr_i = 0, wdata_i = 0, sp_wdata_i = 0, noise = 0;
    logic [7:0] dat [4];
    logic [1:0] bank = 0;
    idm_op_t op_i = IDM_OP_NONE;
    wire logic [7:0] program_status_word_i, rdata_o, special_addr_o, special_wdata_o, stack_pointer_o;
    wire logic rbit_o, rvalid_o, special_req_o, special_write_o;
    logic [7:0] exp_q [$];
    logic       bit_q [$];
    int n_errors = 0, n_tests = 0, cyc = 0;
    idm_core idm_core_inst (.*);
    idm_cpu_status idm_cpu_status_inst (.bank_i(bank), .noise_i(noise), .program_status_word_o(program_status_word_i));
    // Free-running 40 MHz clock and a hard ceiling on run length.
    initial forever #12.5 clock_i = ~clock_i;
    always @(posedge clock_i) begin
        cyc <= cyc + 1;
        if (cyc == 500) begin
            n_errors++;
            close_out();
        end
    end
    task automatic chk(string n, logic [7:0] s, logic [7:0] e);
        n_tests++;
        if (s !== e) begin
            n_errors++;
            $display("CHECK FAILED %s exp %h got %h", n, e, s);
        end
    endtask
    task automatic close_out();
        $display("tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // One request per cycle; the status noise changes with every request.
    task automatic step(idm_op_t o, logic [7:0] a, logic w = 0, logic [7:0] d = 0, logic p = 0);
        op_i <= o;
        addr_i <= a;
        write_i <= w;
        wdata_i <= d;
        wbit_i <= d[0];
        ptr_sel_i <= p;
        noise <= 8'($urandom);
        @(posedge clock_i);
    endtask
    task automatic rd(idm_op_t o, logic [7:0] a, logic [7:0] e);
        exp_q.push_back(e);
        bit_q.push_back(e[a[2:0]]);
        step(o, a);
    endtask
    // Read data is settled mid-cycle; the oldest note is the one due.
    always @(negedge clock_i) begin
        if (rvalid_o === 1'b1) begin
            chk("rdata", rdata_o, exp_q.size() ? exp_q.pop_front() : 8'hXX);
            chk("rbit", 8'(rbit_o), bit_q.size() ? 8'(bit_q.pop_front()) : 8'hXX);
        end
    end
    initial begin
        void'($urandom(32'h53FC));
        repeat (8) @(posedge clock_i);
        nrst_i <= 1;
        #1 chk("sp", stack_pointer_o, 8'h07);
        for (int b = 0; b < 4; b++) begin
            bank <= b[1:0];
            dat[b] = 8'($urandom);
            step(IDM_OP_DIRECT, 8'(b * 8), 1, 8'h90 + 8'(b));
            step(IDM_OP_DIRECT, 8'(b * 8 + 1), 1, 8'h40 + 8'(b));
            step(IDM_OP_INDIRECT, 0, 1, dat[b]);
            step(IDM_OP_INDIRECT, 0, 1, ~dat[b], 1);
            step(IDM_OP_DIRECT, 8'h90 + 8'(b), 1, 8'h00);
        end
        for (int b = 0; b < 4; b++) begin
            bank <= b[1:0];
            rd(IDM_OP_INDIRECT, 0, dat[b]);
            rd(IDM_OP_DIRECT, 8'h40 + 8'(b), ~dat[b]);
        end
        step(IDM_OP_DIRECT, 8'h22, 1, 8'h00);
        step(IDM_OP_DIRECT, 8'h2F, 1, 8'h00);
        step(IDM_OP_BIT, 8'h13, 1, 8'h01);
        step(IDM_OP_BIT, 8'h7F, 1, 8'h01);
        rd(IDM_OP_DIRECT, 8'h22, 8'h08);
        rd(IDM_OP_DIRECT, 8'h2F, 8'h80);
        rd(IDM_OP_BIT, 8'h13, 8'h08);
        rd(IDM_OP_BIT, 8'h12, 8'h08);
        step(IDM_OP_BIT, 8'h85, 1, 8'h01);
        sp_load_i <= 1;
        sp_wdata_i <= 8'hFE;
        @(posedge clock_i);
        sp_load_i <= 0;
        step(IDM_OP_PUSH, 0, 0, dat[0]);
        step(IDM_OP_PUSH, 0, 0, dat[1]);
        #1 chk("sp", stack_pointer_o, 8'h00);
        rd(IDM_OP_POP, 0, dat[1]);
        rd(IDM_OP_POP, 0, dat[0]);
        en_i <= 0;
        step(IDM_OP_PUSH, 0, 0, 8'h55);
        en_i <= 1;
        op_i <= IDM_OP_NONE;
        #1 chk("sp", stack_pointer_o, 8'hFE);
        nrst_i <= 0;
        @(posedge clock_i);
        nrst_i <= 1;
        #1 chk("sp", stack_pointer_o, 8'h07);
        step(IDM_OP_PUSH, 0, 0, 8'h5A);
        rd(IDM_OP_DIRECT, 8'h08, 8'h5A);
        rd(IDM_OP_DIRECT, 8'h41, ~dat[1]);
        step(IDM_OP_NONE, 0);
        repeat (3) @(posedge clock_i);
        chk("queue", 8'(exp_q.size()), 8'h00);
        close_out();
    end
endmodule // idm_core_tb
`default_nettype wire

// >>> verification/idm_cpu_status.sv
// Model of the core's status word feeding the bank selection.
`timescale 1ns/1ps
`default_nettype none
module idm_cpu_status (
    input  wire logic [1:0] bank_i,
    input  wire logic [7:0] noise_i,
    output logic [7:0]      program_status_word_o
);
    // bank field placement
    // Other flags carry noise, so a decode that leans on them shows up.
    assign program_status_word_o = {noise_i[7:5], bank_i, noise_i[2:0]};
endmodule // idm_cpu_status
`default_nettype wire
